/* src/irsc_regs.svh */
`ifndef IRSC_REGS_SVH
`define IRSC_REGS_SVH
// Register addresses on the plain register port.
`define IRSC_ADDR_CR1 4'h0
`define IRSC_ADDR_CR2 4'h1
`define IRSC_ADDR_CR3 4'h2
`define IRSC_ADDR_SR1 4'h3
`define IRSC_ADDR_DATA 4'h4
`define IRSC_ADDR_BAUD 4'h5
// Control register one fields.
`define IRSC_CR1_ENABLE 6
`define IRSC_CR1_NINEBIT 4
`define IRSC_CR1_WAKESEL 3
`define IRSC_CR1_IDLETYPE 2
// Control register two fields.
`define IRSC_CR2_RXIE 5
`define IRSC_CR2_IDLEIE 4
`define IRSC_CR2_TXEN 3
`define IRSC_CR2_RXEN 2
`define IRSC_CR2_STANDBY 1
`define IRSC_CR2_BREAK 0
// Control register three fields.
`define IRSC_CR3_RX9 7
`define IRSC_CR3_TX9 6
`define IRSC_CR3_OVERRUN_INTERRUPT_ENABLE 3
`define IRSC_CR3_NOISE_INTERRUPT_ENABLE 2
`define IRSC_CR3_FEIE 1
`define IRSC_CR3_PEIE 0
// Status register one fields.
`define IRSC_SR1_TXEMPTY 7
`define IRSC_SR1_RXFULL 5
`define IRSC_SR1_IDLE 4
`define IRSC_SR1_OVERRUN 3
`define IRSC_SR1_NOISE 2
`define IRSC_SR1_FRAMING 1
// Receiver sample clock figures.
`define IRSC_RT_PER_BIT 5'h10
`define IRSC_RT_LAST 4'hF
`define IRSC_RT_S1 4'h7
`define IRSC_RT_S2 4'h8
`define IRSC_RT_S3 4'h9
`define IRSC_IDLE_BITS 4'hA
`define IRSC_BAUD_RESET 8'h05
`endif

/* src/irsc_pkg.sv */
package irsc_pkg;
	typedef enum logic [1:0]
	{
		IRSC_RX_IDLE = 2'b00,
		IRSC_RX_START = 2'b01,
		IRSC_RX_DATA = 2'b10,
		IRSC_RX_STOP = 2'b11
	} irsc_rxstate_t;
	typedef logic [8:0] irsc_word_t;
endpackage : irsc_pkg

/* src/irsc_tick_if.sv */
`timescale 1ns/1ps
interface irsc_tick_if;
	logic rtTick;
	logic bitTick;
	modport source (output rtTick, output bitTick);
	modport sink (input rtTick, input bitTick);
endinterface : irsc_tick_if

/* src/irsc_rt_divider.sv */
`timescale 1ns/1ps
`include "irsc_regs.svh"
module irsc_rt_divider
(
	// Clock and reset.
	input wire logic clock,
	input wire logic arst_n,
	// Divisor from the baud register.
	input wire logic [7:0] divisor,
	// Tick outputs.
	irsc_tick_if.source ticks
);
	logic [7:0] divCount_reg;
	logic [3:0] rtCount_reg;
	logic rtTick_reg;
	logic bitTick_reg;
	wire divDone = (divCount_reg == 8'h00);
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			divCount_reg <= 8'h00;
			rtCount_reg <= 4'h0;
			rtTick_reg <= 1'b0;
			bitTick_reg <= 1'b0;
		end
		else
		begin
			divCount_reg <= divDone ? divisor : divCount_reg - 8'h01;
			rtTick_reg <= divDone;
			bitTick_reg <= divDone && (rtCount_reg == `IRSC_RT_LAST);
			if (divDone)
				rtCount_reg <= rtCount_reg + 4'h1;
		end
	end
	assign ticks.rtTick = rtTick_reg;
	assign ticks.bitTick = bitTick_reg;
endmodule : irsc_rt_divider

/* src/irsc_receiver_control.sv */
`timescale 1ns/1ps
`include "irsc_regs.svh"
module irsc_receiver_control
(
	// Clock and reset.
	input wire logic clock,
	input wire logic arst_n,
	// Register port.
	input wire logic [3:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [7:0] regRdData,
	// Serial lines.
	input wire logic rxdPin,
	output logic txdPin,
	// Interrupt requests.
	output logic rxIrq,
	output logic errIrq
);
	import irsc_pkg::*;
	irsc_tick_if ticks();
	logic [7:0] cr1_reg, cr2_reg, cr3_reg, baud_reg;
	logic rxSync1_reg, rxSync2_reg, rxPrev_reg;
	irsc_rxstate_t rxState_reg;
	logic [3:0] rtPhase_reg;
	logic [3:0] bitIdx_reg;
	irsc_word_t shift_reg;
	logic [7:0] data_reg;
	logic [2:0] stopSmp_reg;
	logic charNoise_reg;
	logic [3:0] onesCount_reg;
	logic idleArmed_reg;
	logic full_reg, idle_reg, overrun_reg, noise_reg, framing_reg;
	logic [3:0] txBit_reg;
	logic txBusy_reg, txLine_reg;
	logic rxIrq_reg, errIrq_reg;
	logic [7:0] rdData_reg;

	irsc_rt_divider divider (.clock(clock), .arst_n(arst_n), .divisor(baud_reg),
		.ticks(ticks.source));

	// Decode.
	wire modEn = cr1_reg[`IRSC_CR1_ENABLE];
	wire nineBit = cr1_reg[`IRSC_CR1_NINEBIT];
	wire wakeSel = cr1_reg[`IRSC_CR1_WAKESEL];
	wire idleType = cr1_reg[`IRSC_CR1_IDLETYPE];
	wire rxEn = cr2_reg[`IRSC_CR2_RXEN];
	wire txEn = cr2_reg[`IRSC_CR2_TXEN];
	wire standby = cr2_reg[`IRSC_CR2_STANDBY];
	wire sendBreak = cr2_reg[`IRSC_CR2_BREAK];
	wire wrCr1 = regWrite && (regAddr == `IRSC_ADDR_CR1);
	wire wrCr2 = regWrite && (regAddr == `IRSC_ADDR_CR2);
	wire wrCr3 = regWrite && (regAddr == `IRSC_ADDR_CR3);
	wire wrBaud = regWrite && (regAddr == `IRSC_ADDR_BAUD);
	wire wrData = regWrite && (regAddr == `IRSC_ADDR_DATA);
	wire rdData = regRead && (regAddr == `IRSC_ADDR_DATA);
	wire rt = ticks.rtTick;
	wire rxLine = rxSync2_reg;
	wire fallEdge = rxPrev_reg && !rxLine;
	wire [3:0] lastBit = nineBit ? 4'h8 : 4'h7;

	// Enable bits keep their value when the module is off.
	wire [7:0] cr2Gated = modEn ? regWrData :
		{regWrData[7:4], cr2_reg[`IRSC_CR2_TXEN:`IRSC_CR2_RXEN], regWrData[1:0]};

	// Stop-bit vote: zero bad is clean, one is noise, more is framing.
	wire [1:0] stopOnes = {1'b0, stopSmp_reg[0]} + {1'b0, stopSmp_reg[1]} +
		{1'b0, rxLine};
	wire stopNoise = (stopOnes == 2'h2);
	wire stopFrame = (stopOnes < 2'h2);
	wire stopSample = rxEn && rt && (rxState_reg == IRSC_RX_STOP) &&
		(rtPhase_reg == `IRSC_RT_S3);
	wire brkChar = (shift_reg == 9'h000);
	wire msbMark = nineBit ? shift_reg[8] : shift_reg[7];
	wire wakeAddr = standby && wakeSel && msbMark;
	wire doneChar = stopSample && (!standby || wakeAddr);
	wire onesTick = rxEn && rt && (rtPhase_reg == `IRSC_RT_S2) && rxLine;
	wire idleHit = idleArmed_reg && (onesCount_reg == `IRSC_IDLE_BITS) && onesTick;
	wire wakeIdle = idleHit && standby && !wakeSel;

	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rxSync1_reg <= 1'b1;
			rxSync2_reg <= 1'b1;
			rxPrev_reg <= 1'b1;
		end
		else
		begin
			rxSync1_reg <= rxdPin;
			rxSync2_reg <= rxSync1_reg;
			rxPrev_reg <= rxSync2_reg;
		end
	end

	// Control registers; hardware wakeup clears the standby bit.
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cr1_reg <= 8'h00;
			cr2_reg <= 8'h00;
			cr3_reg <= 8'h00;
			baud_reg <= `IRSC_BAUD_RESET;
		end
		else
		begin
			if (wrCr1)
				cr1_reg <= regWrData;
			if (wrCr2)
				cr2_reg <= cr2Gated;
			else if (wakeAddr && stopSample || wakeIdle)
				cr2_reg[`IRSC_CR2_STANDBY] <= 1'b0;
			if (wrCr3)
				cr3_reg[6:0] <= regWrData[6:0];
			if (doneChar && !full_reg)
				cr3_reg[`IRSC_CR3_RX9] <= shift_reg[8];
			if (wrBaud)
				baud_reg <= regWrData;
		end
	end

	// Receiver sequencer, realigned on each falling edge inside a character.
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rxState_reg <= IRSC_RX_IDLE;
			rtPhase_reg <= 4'h0;
			bitIdx_reg <= 4'h0;
			shift_reg <= 9'h000;
			stopSmp_reg <= 3'b000;
			charNoise_reg <= 1'b0;
		end
		else if (!rxEn)
			rxState_reg <= IRSC_RX_IDLE;
		else if (rxState_reg == IRSC_RX_IDLE)
		begin
			if (fallEdge)
			begin
				rxState_reg <= IRSC_RX_START;
				rtPhase_reg <= 4'h0;
				charNoise_reg <= 1'b0;
			end
			// The phase keeps running on an idle line, or idle bits would never be counted.
			else if (rt)
				rtPhase_reg <= rtPhase_reg + 4'h1;
		end
		else if (fallEdge)
			rtPhase_reg <= 4'h0;
		else if (rt)
		begin
			rtPhase_reg <= rtPhase_reg + 4'h1;
			if (rtPhase_reg == `IRSC_RT_S1 || rtPhase_reg == `IRSC_RT_S2)
				stopSmp_reg <= {stopSmp_reg[1:0], rxLine};
			if (rtPhase_reg == `IRSC_RT_S3)
			begin
				// Majority vote on each bit; a split vote marks noise.
				if ((stopSmp_reg[0] != rxLine) || (stopSmp_reg[1] != rxLine))
					charNoise_reg <= 1'b1;
				unique case (rxState_reg)
					IRSC_RX_START:
					begin
						rxState_reg <= (stopOnes >= 2'h2) ? IRSC_RX_IDLE : IRSC_RX_DATA;
						bitIdx_reg <= 4'h0;
					end
					IRSC_RX_DATA:
					begin
						shift_reg <= {(stopOnes >= 2'h2), shift_reg[8:1]};
						if (bitIdx_reg == lastBit)
							rxState_reg <= IRSC_RX_STOP;
						bitIdx_reg <= bitIdx_reg + 4'h1;
					end
					IRSC_RX_STOP:
						rxState_reg <= IRSC_RX_IDLE;
					IRSC_RX_IDLE:
						rxState_reg <= IRSC_RX_IDLE;
				endcase
				if (rxState_reg == IRSC_RX_DATA && !nineBit && bitIdx_reg == lastBit)
					shift_reg <= {1'b0, (stopOnes >= 2'h2), shift_reg[8:2]};
			end
		end
	end

	// Idle counting of consecutive ones.
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			onesCount_reg <= 4'h0;
			idleArmed_reg <= 1'b0;
		end
		else if (!rxLine)
		begin
			onesCount_reg <= 4'h0;
			idleArmed_reg <= 1'b1;
		end
		else if (idleType && (rxState_reg != IRSC_RX_IDLE))
			onesCount_reg <= 4'h0;
		else if (idleHit)
			idleArmed_reg <= 1'b0;
		else if (onesTick && onesCount_reg != `IRSC_IDLE_BITS)
			onesCount_reg <= onesCount_reg + 4'h1;
	end

	// Status flags; a set in the same cycle as a data read wins.
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			data_reg <= 8'h00;
			full_reg <= 1'b0;
			idle_reg <= 1'b0;
			overrun_reg <= 1'b0;
			noise_reg <= 1'b0;
			framing_reg <= 1'b0;
		end
		else
		begin
			if (rdData)
			begin
				full_reg <= 1'b0;
				idle_reg <= 1'b0;
				overrun_reg <= 1'b0;
				noise_reg <= 1'b0;
				framing_reg <= 1'b0;
			end
			if (doneChar && full_reg && !rdData)
				overrun_reg <= 1'b1;
			else if (doneChar)
			begin
				data_reg <= shift_reg[7:0];
				full_reg <= 1'b1;
				framing_reg <= stopFrame || brkChar;
				noise_reg <= stopNoise || charNoise_reg;
			end
			if (idleHit && !standby)
				idle_reg <= 1'b1;
		end
	end

	// Transmitter: break characters only, back to back while the break bit is set, then the line marks.
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			txBit_reg <= 4'h0;
			txBusy_reg <= 1'b0;
			txLine_reg <= 1'b1;
		end
		else if (ticks.bitTick)
		begin
			if (txEn && (sendBreak || txBusy_reg))
			begin
				txLine_reg <= 1'b0;
				txBusy_reg <= 1'b1;
				txBit_reg <= txBit_reg + 4'h1;
				if (txBit_reg == (nineBit ? 4'hA : 4'h9))
				begin
					txBit_reg <= 4'h0;
					txBusy_reg <= 1'b0;
					txLine_reg <= sendBreak ? 1'b0 : 1'b1;
				end
			end
			else
				txLine_reg <= 1'b1;
		end
	end

	// The receive interrupt is held off while in standby; the error interrupt is not.
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rxIrq_reg <= 1'b0;
			errIrq_reg <= 1'b0;
			rdData_reg <= 8'h00;
		end
		else
		begin
			rxIrq_reg <= !standby && ((full_reg && cr2_reg[`IRSC_CR2_RXIE]) ||
				(idle_reg && cr2_reg[`IRSC_CR2_IDLEIE]));
			errIrq_reg <= (overrun_reg && cr3_reg[`IRSC_CR3_OVERRUN_INTERRUPT_ENABLE]) ||
				(noise_reg && cr3_reg[`IRSC_CR3_NOISE_INTERRUPT_ENABLE]) ||
				(framing_reg && cr3_reg[`IRSC_CR3_FEIE]);
			if (regRead)
				unique case (regAddr)
					`IRSC_ADDR_CR1: rdData_reg <= cr1_reg;
					`IRSC_ADDR_CR2: rdData_reg <= cr2_reg;
					`IRSC_ADDR_CR3: rdData_reg <= cr3_reg;
					`IRSC_ADDR_SR1: rdData_reg <= {!txBusy_reg, 1'b0, full_reg, idle_reg,
						overrun_reg, noise_reg, framing_reg, 1'b0};
					`IRSC_ADDR_DATA: rdData_reg <= data_reg;
					`IRSC_ADDR_BAUD: rdData_reg <= baud_reg;
					default: rdData_reg <= 8'h00;
				endcase
		end
	end

	wire unusedData = wrData;
	assign regRdData = rdData_reg;
	assign txdPin = txLine_reg;
	assign rxIrq = rxIrq_reg;
	assign errIrq = errIrq_reg;

	frame_with_full_a: assert property (@(posedge clock) disable iff (!arst_n)
		$rose(framing_reg) |-> full_reg && $rose(full_reg))
		else $error("framing flag rose without receive full");
	overrun_keeps_a: assert property (@(posedge clock) disable iff (!arst_n)
		(doneChar && full_reg && !rdData) |=> $stable(data_reg) && overrun_reg)
		else $error("overrun changed data");
	standby_quiet_a: assert property (@(posedge clock) disable iff (!arst_n)
		standby |=> !rxIrq)
		else $error("interrupt while in standby");
	enable_block_a: assert property (@(posedge clock) disable iff (!arst_n)
		(wrCr2 && !modEn) |=> $stable(cr2_reg[`IRSC_CR2_RXEN]))
		else $error("receiver enable written while disabled");
	idle_wake_a: assert property (@(posedge clock) disable iff (!arst_n)
		(wakeIdle && !wrCr2) |=> !standby && !idle_reg)
		else $error("idle wakeup wrong");
	break_line_a: assert property (@(posedge clock) disable iff (!arst_n)
		(txEn && sendBreak && ticks.bitTick) |=> !txdPin)
		else $error("break not driven");
	rx_off_a: assert property (@(posedge clock) disable iff (!arst_n)
		!rxEn |=> rxState_reg == IRSC_RX_IDLE)
		else $error("receiver ran while disabled");
	noise_vote_a: assert property (@(posedge clock) disable iff (!arst_n)
		(doneChar && !full_reg && stopNoise) |=> noise_reg && !framing_reg ||
		brkChar)
		else $error("single bad stop sample not noise");
endmodule : irsc_receiver_control

/* test/irsc_remote_tx.sv */
`timescale 1ns/1ps
module irsc_remote_tx
#(
	parameter int BitClk = 96,
	parameter int LateClk = 49
)
(
	// Clock.
	input wire logic clock,
	// Line toward the receiver, idle high.
	output logic rxdLine
);
	initial rxdLine = 1'b1;
	// Start, eight data bits LSB first, then a stop bit of the chosen level.
	// A late stop bit stretches the last data bit so that only the first stop sample still
	// sees it; a glitch inside the stop bit would realign the receiver instead of noise.
	task automatic send(input logic [7:0] data, input logic stopLvl, input logic late);
		int i;
		rxdLine <= 1'b0;
		repeat (BitClk) @(posedge clock);
		for (i = 0; i < 8; i++)
		begin
			rxdLine <= data[i];
			repeat (BitClk) @(posedge clock);
		end
		if (late)
			repeat (LateClk) @(posedge clock);
		rxdLine <= stopLvl;
		repeat (BitClk) @(posedge clock);
		rxdLine <= 1'b1;
		repeat (2 * BitClk) @(posedge clock);
	endtask : send
endmodule : irsc_remote_tx

/* test/irsc_receiver_control_bench.sv */
`timescale 1ns/1ps
`include "irsc_regs.svh"
module irsc_receiver_control_bench;
	localparam int BitClk = (`IRSC_BAUD_RESET + 1) * 16;
	logic clock;
	logic arst_n;
	logic [3:0] regAddr;
	logic [7:0] regWrData;
	logic regWrite;
	logic regRead;
	logic [7:0] regRdData;
	logic rxdPin;
	logic txdPin;
	logic rxIrq;
	logic errIrq;
	logic [7:0] rv;
	int nErrors;
	int comparisons;
	irsc_receiver_control dut_u (.clock(clock), .arst_n(arst_n), .regAddr(regAddr),
		.regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
		.regRdData(regRdData), .rxdPin(rxdPin), .txdPin(txdPin), .rxIrq(rxIrq),
		.errIrq(errIrq));
	irsc_remote_tx #(.BitClk(BitClk)) remote_u (.clock(clock), .rxdLine(rxdPin));
	initial
	begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
		comparisons++;
		if (seen !== exp)
		begin
			nErrors++;
			$display("FAIL %0t %s: saw %h expected %h", $time, what, seen, exp);
		end
	endtask : check
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock);
		regWrite <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge clock);
		regWrite <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a);
		@(posedge clock);
		regRead <= 1'b1;
		regAddr <= a;
		@(posedge clock);
		regRead <= 1'b0;
		#1;
		rv = regRdData;
	endtask : rd
	function automatic logic [7:0] irqs();
		return {6'h00, rxIrq, errIrq};
	endfunction : irqs
	task automatic give_verdict;
		$display("Comparisons %0d, mismatches %0d", comparisons, nErrors);
		if (nErrors == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : give_verdict
	task automatic t_reset_gate;
		rd(`IRSC_ADDR_CR2);
		check(rv, 8'h00, "cr2 reset");
		rd(`IRSC_ADDR_BAUD);
		check(rv, `IRSC_BAUD_RESET, "baud reset");
		rd(4'hF);
		check(rv, 8'h00, "unmapped read");
		check({5'h00, txdPin, rxIrq, errIrq}, 8'h04, "idle outputs");
		wr(`IRSC_ADDR_CR2, 8'h0C);
		rd(`IRSC_ADDR_CR2);
		check(rv, 8'h00, "enables blocked");
		wr(`IRSC_ADDR_CR1, 8'h40);
		wr(`IRSC_ADDR_CR2, 8'h2C);
		rd(`IRSC_ADDR_CR2);
		check(rv, 8'h2C, "enables taken");
		$display("test reset and gating done");
	endtask : t_reset_gate
	task automatic t_receive;
		remote_u.send(8'hA5, 1'b1, 1'b0);
		rd(`IRSC_ADDR_SR1);
		check(rv & 8'h22, 8'h20, "full only");
		check(irqs(), 8'h02, "receive irq");
		wr(`IRSC_ADDR_CR2, 8'h08);
		rd(`IRSC_ADDR_SR1);
		check(rv & 8'h20, 8'h20, "flag kept");
		check(irqs(), 8'h00, "irq masked");
		rd(`IRSC_ADDR_DATA);
		check(rv, 8'hA5, "data");
		wr(`IRSC_ADDR_CR2, 8'h2C);
		$display("test receive done");
	endtask : t_receive
	task automatic t_errors;
		wr(`IRSC_ADDR_CR3, 8'h02);
		rd(`IRSC_ADDR_CR3);
		check(rv, 8'h02, "third register enables");
		remote_u.send(8'h3C, 1'b0, 1'b0);
		rd(`IRSC_ADDR_SR1);
		check(rv & 8'h22, 8'h22, "framing with full");
		check(irqs(), 8'h03, "framing irq");
		rd(`IRSC_ADDR_DATA);
		remote_u.send(8'h00, 1'b0, 1'b0);
		rd(`IRSC_ADDR_SR1);
		check(rv & 8'h02, 8'h02, "break framing");
		rd(`IRSC_ADDR_DATA);
		wr(`IRSC_ADDR_CR3, 8'h04);
		remote_u.send(8'h5A, 1'b1, 1'b1);
		rd(`IRSC_ADDR_SR1);
		check(rv & 8'h06, 8'h04, "noise not framing");
		check(irqs() & 8'h01, 8'h01, "noise irq");
		rd(`IRSC_ADDR_DATA);
		wr(`IRSC_ADDR_CR3, 8'h08);
		remote_u.send(8'h11, 1'b1, 1'b0);
		remote_u.send(8'h22, 1'b1, 1'b0);
		rd(`IRSC_ADDR_SR1);
		check(rv & 8'h28, 8'h28, "overrun");
		check(irqs() & 8'h01, 8'h01, "overrun irq");
		rd(`IRSC_ADDR_DATA);
		check(rv, 8'h11, "old data kept");
		$display("test errors done");
	endtask : t_errors
	task automatic t_wakeup;
		wr(`IRSC_ADDR_CR1, 8'h48);
		wr(`IRSC_ADDR_CR2, 8'h2E);
		remote_u.send(8'h01, 1'b1, 1'b0);
		rd(`IRSC_ADDR_CR2);
		check(rv & 8'h02, 8'h02, "still standby");
		check(irqs() & 8'h02, 8'h00, "irq suppressed");
		rd(`IRSC_ADDR_DATA);
		remote_u.send(8'h81, 1'b1, 1'b0);
		rd(`IRSC_ADDR_CR2);
		check(rv & 8'h02, 8'h00, "mark wakes");
		rd(`IRSC_ADDR_SR1);
		check(rv & 8'h20, 8'h20, "mark sets full");
		rd(`IRSC_ADDR_DATA);
		check(rv, 8'h81, "mark data");
		wr(`IRSC_ADDR_CR1, 8'h40);
		wr(`IRSC_ADDR_CR2, 8'h3C);
		remote_u.send(8'h0F, 1'b1, 1'b0);
		// Clearing the full flag first leaves the idle flag as the only interrupt source.
		rd(`IRSC_ADDR_DATA);
		repeat (12 * BitClk) @(posedge clock);
		rd(`IRSC_ADDR_SR1);
		check(rv & 8'h10, 8'h10, "idle flag");
		check(irqs() & 8'h02, 8'h02, "idle irq");
		rd(`IRSC_ADDR_DATA);
		wr(`IRSC_ADDR_CR2, 8'h3E);
		remote_u.send(8'h0F, 1'b1, 1'b0);
		repeat (12 * BitClk) @(posedge clock);
		rd(`IRSC_ADDR_CR2);
		check(rv & 8'h02, 8'h00, "idle wakes");
		rd(`IRSC_ADDR_SR1);
		check(rv & 8'h10, 8'h00, "waking idle silent");
		$display("test wakeup done");
	endtask : t_wakeup
	task automatic t_break;
		int lows;
		int i;
		lows = 0;
		// The break bit is toggled long after the transmitter came up, never at once.
		wr(`IRSC_ADDR_CR2, 8'h09);
		repeat (BitClk) @(posedge clock);
		for (i = 0; i < 20; i++)
		begin
			repeat (BitClk) @(posedge clock);
			if (txdPin === 1'b0)
				lows++;
		end
		check(8'(lows), 8'h14, "breaks back to back");
		wr(`IRSC_ADDR_CR2, 8'h08);
		i = 0;
		while (txdPin !== 1'b1 && i < 12 * BitClk)
		begin
			@(posedge clock);
			i++;
		end
		repeat (BitClk) @(posedge clock);
		check({7'h00, txdPin}, 8'h01, "line high after break");
		$display("test break done");
	endtask : t_break
	initial
	begin
		nErrors = 0;
		comparisons = 0;
		arst_n = 1'b0;
		regAddr = 4'h0;
		regWrData = 8'h00;
		regWrite = 1'b0;
		regRead = 1'b0;
		repeat (4) @(posedge clock);
		arst_n <= 1'b1;
		t_reset_gate();
		t_receive();
		t_errors();
		t_wakeup();
		t_break();
		give_verdict();
	end
	initial
	begin
		repeat (60000) @(posedge clock);
		nErrors++;
		$display("FAIL %0t watchdog expired", $time);
		give_verdict();
	end
endmodule : irsc_receiver_control_bench
